// *** verilog/ltrc_params.svh ***
// Constants for the loopback test and restart control block
// Summary of operation
// RQ1: Restart link after unframed run: 50 s startup, 4 s data, 60 s test.
// RQ2: Pattern generator stops itself after 45 s, normal path returns.
// RQ3: After pattern timeout, error indicator blinks until selector is normal.
// RQ4: Local loop request gives mode 1 when unlinked, mode 2 when linked.
// RQ5: Mode 1 loops local terminal data in loop control; line data invalid.
// RQ6: In mode 1 far unit stays in startup; release returns both to startup.
// RQ7: Mode 2 loops local data in framer, far-end data in loop control.
// RQ8: Releasing mode 2 returns to data mode with normal paths.
// RQ9: Mode 1 with pattern routes generator through loop control to detector.
// RQ10: Starting the pattern generator sets restart threshold to one minute.
// RQ11: Pattern in mode 1 is not delivered to either terminal.
// RQ12: In mode 2 the local pattern generator is unavailable.
// RQ13: Remote loop request sends loop-on; far unit answers loop acknowledge.
// RQ14: Remote loop end loops line data back and passes it to its terminal.
// RQ15: Remote loop end uses a one minute restart threshold.
// RQ16: Remote loop end ignores its own terminal transmit data.
// RQ17: Dropping remote loop sends loop-off; test indicator held until sent.
// RQ18: Switch set again during termination is ignored until returned normal.
// RQ19: Remote loop pattern test uses one minute threshold and checks errors.
// RQ20: Clear-to-send and carrier follow reception of framed packets.
// RQ21: Error indicator pulses on CRC error while no pattern runs, or on pattern bit error while it runs.
// RQ22: Unframed duration counter clears on every framed packet.
// RQ23: Timeouts count a one second tick; counters reset on mode entry (code: on a threshold change or generator start).
`ifndef LTRC_PARAMS_SVH
`define LTRC_PARAMS_SVH
`define LTRC_CLK_HZ 100000000
`define LTRC_RESTART_STARTUP_S 6'h32
`define LTRC_RESTART_DATA_S 6'h04
`define LTRC_RESTART_TEST_S 6'h3c
`define LTRC_PATTERN_S 6'h2d
`define LTRC_BLINK_MS 500
`define LTRC_FLASH_MS 50
`define LTRC_ADR_CTRL 4'h0
`define LTRC_ADR_STATUS 4'h4
`define LTRC_CTRL_LOCAL 0
`define LTRC_CTRL_REMOTE 1
`define LTRC_CTRL_PAT 3:2
`define LTRC_EOC_LOOP_ON 2'h1
`define LTRC_EOC_LOOP_ACK 2'h2
`define LTRC_EOC_LOOP_OFF 2'h3
`endif

// *** verilog/ltrc_pkg.sv ***
// Types for the loopback test and restart control block
package ltrc_pkg;
  typedef enum logic [2:0] {
    MODE_NORMAL, MODE_LOCAL1, MODE_LOCAL2, MODE_RDL_ON,
    MODE_RDL_LOCAL, MODE_RDL_OFF, MODE_RDL_END
  } ltrc_mode_type;
  typedef enum logic {LINK_STARTUP, LINK_DATA} ltrc_link_type;
endpackage

// *** verilog/ltrc_loop_test_ctrl.sv ***
// Test mode, loopback and restart control with Wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "ltrc_params.svh"
module ltrc_loop_test_ctrl
  import ltrc_pkg::*;
#(
  parameter int TICK_CYCLES = `LTRC_CLK_HZ,
  parameter int BLINK_CYCLES = `LTRC_CLK_HZ / 1000 * `LTRC_BLINK_MS,
  parameter int FLASH_CYCLES = `LTRC_CLK_HZ / 1000 * `LTRC_FLASH_MS
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic swLocalLoop,
  input wire logic swRemoteLoop,
  input wire logic [1:0] prbsPatternSelect,
  input wire logic termLocalLoop,
  input wire logic termRemoteLoop,
  input wire logic framedPacket,
  input wire logic unframedPacket,
  input wire logic crcError,
  input wire logic patBitError,
  input wire logic eocRxValid,
  input wire logic [1:0] eocRxCode,
  input wire logic eocTxReady,
  output logic eocTxValid,
  output logic [1:0] eocTxCode,
  output logic restartPulse,
  output logic clearToSend,
  output logic carrierDetect,
  output logic noLinkIndicator,
  output logic errorIndicator,
  output logic testModeIndicator,
  output logic patGenEnable,
  output logic patErrInject,
  output logic loopTermAtCtl,
  output logic loopTermAtFramer,
  output logic loopLineAtCtl,
  output logic patToDetector,
  output logic termRxValid,
  output logic termTxIgnore
);

  ltrc_mode_type mode_reg;
  ltrc_link_type link_reg;
  logic [3:0] ctrl_reg;
  logic [5:0] pinSync1_reg;
  logic [5:0] pinSync2_reg;
  logic [5:0] pinSync3_reg;
  logic [5:0] pin_reg;
  logic [31:0] tickCnt_reg;
  logic tick_reg;
  logic [5:0] unframedSecs_reg;
  logic [5:0] threshold_reg;
  logic [5:0] threshold_next;
  logic [5:0] patSecs_reg;
  logic patActive_reg;
  logic patTimeout_reg;
  logic swIgnore_reg;
  logic [31:0] blinkCnt_reg;
  logic blink_reg;
  logic [31:0] flashCnt_reg;
  logic localReq;
  logic remoteReq;
  logic patReq;
  logic linked;
  logic restartNow;
  logic rxLoopOn;
  logic rxLoopAck;
  logic rxLoopOff;
  logic txDone;
  logic sendOn;
  logic sendOff;
  logic sendAck;
  logic wbReq;

  // Restart threshold in seconds for the current mode
  function automatic logic [5:0] restartLimit(
    input ltrc_link_type link,
    input ltrc_mode_type mode,
    input logic patOn
  );
    if (patOn || mode == MODE_RDL_END) begin
      restartLimit = `LTRC_RESTART_TEST_S; // RQ10 RQ15 RQ19
    end else if (link == LINK_DATA) begin
      restartLimit = `LTRC_RESTART_DATA_S; // RQ1
    end else begin
      restartLimit = `LTRC_RESTART_STARTUP_S; // RQ1
    end
  endfunction

  // Switches and terminal requests: three-stage synchroniser
  always_ff @(posedge clock) begin
    if (srst) begin
      pinSync1_reg <= 6'h00;
      pinSync2_reg <= 6'h00;
      pinSync3_reg <= 6'h00;
      pin_reg <= 6'h00;
    end else begin
      pinSync1_reg <= {prbsPatternSelect, termRemoteLoop, termLocalLoop,
                       swRemoteLoop, swLocalLoop};
      pinSync2_reg <= pinSync1_reg;
      pinSync3_reg <= pinSync2_reg;
      for (int i = 0; i < 6; i++) begin
        if (pinSync2_reg[i] == pinSync3_reg[i]) begin
          pin_reg[i] <= pinSync3_reg[i];
        end
      end
    end
  end

  assign linked = (link_reg == LINK_DATA);
  assign patReq = (pin_reg[5:4] != 2'h0) || (ctrl_reg[`LTRC_CTRL_PAT] != 2'h0);
  assign localReq = pin_reg[0] | pin_reg[2] | ctrl_reg[`LTRC_CTRL_LOCAL];
  assign remoteReq = (pin_reg[1] & ~swIgnore_reg) | pin_reg[3] |
                     ctrl_reg[`LTRC_CTRL_REMOTE];
  assign rxLoopOn = eocRxValid && eocRxCode == `LTRC_EOC_LOOP_ON;
  assign rxLoopAck = eocRxValid && eocRxCode == `LTRC_EOC_LOOP_ACK;
  assign rxLoopOff = eocRxValid && eocRxCode == `LTRC_EOC_LOOP_OFF;
  assign txDone = eocTxValid & eocTxReady;
  assign threshold_next = restartLimit(link_reg, mode_reg, patActive_reg);
  assign restartNow = tick_reg && !framedPacket &&
                      (unframedSecs_reg >= threshold_reg); // RQ22
  assign sendAck = (mode_reg == MODE_NORMAL) && rxLoopOn; // RQ13
  assign sendOn = (mode_reg == MODE_NORMAL) && !rxLoopOn && !localReq &&
                  remoteReq && linked; // RQ13
  assign sendOff = (mode_reg == MODE_RDL_ON || mode_reg == MODE_RDL_LOCAL)
                   && !remoteReq && !restartNow; // RQ17

  // One second tick for every timeout
  always_ff @(posedge clock) begin
    if (srst) begin
      tickCnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else if (tickCnt_reg >= 32'(TICK_CYCLES - 1)) begin
      tickCnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b1; // RQ23
    end else begin
      tickCnt_reg <= tickCnt_reg + 32'h0000_0001;
      tick_reg <= 1'b0;
    end
  end

  // Unframed run length; a change of threshold restarts the count
  always_ff @(posedge clock) begin
    if (srst) begin
      unframedSecs_reg <= 6'h00;
      threshold_reg <= `LTRC_RESTART_STARTUP_S;
      restartPulse <= 1'b0;
    end else begin
      threshold_reg <= threshold_next;
      restartPulse <= restartNow; // RQ1
      if (framedPacket || restartNow) begin
        unframedSecs_reg <= 6'h00; // RQ22
      end else if (threshold_next != threshold_reg) begin
        unframedSecs_reg <= 6'h00; // RQ23
      end else if (tick_reg) begin
        unframedSecs_reg <= unframedSecs_reg + 6'h01;
      end
    end
  end

  // Line state: startup until framed packets arrive
  always_ff @(posedge clock) begin
    if (srst) begin
      link_reg <= LINK_STARTUP;
    end else if (restartNow) begin
      link_reg <= LINK_STARTUP; // RQ1
    end else if (mode_reg == MODE_LOCAL1) begin
      link_reg <= LINK_STARTUP; // RQ6
    end else if (mode_reg == MODE_LOCAL2 && !localReq) begin
      link_reg <= LINK_DATA; // RQ8
    end else if (framedPacket) begin
      link_reg <= LINK_DATA;
    end
  end

  // Test mode sequencing
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_reg <= MODE_NORMAL;
    end else begin
      case (mode_reg)
        MODE_NORMAL: begin
          if (rxLoopOn) begin
            mode_reg <= MODE_RDL_END; // RQ13
          end else if (localReq) begin
            mode_reg <= linked ? MODE_LOCAL2 : MODE_LOCAL1; // RQ4
          end else if (sendOn) begin
            mode_reg <= MODE_RDL_ON;
          end
        end
        MODE_LOCAL1: begin
          if (!localReq) begin
            mode_reg <= MODE_NORMAL; // RQ6
          end
        end
        MODE_LOCAL2: begin
          if (!localReq) begin
            mode_reg <= MODE_NORMAL; // RQ8
          end
        end
        MODE_RDL_ON: begin
          if (restartNow) begin
            mode_reg <= MODE_NORMAL;
          end else if (sendOff) begin
            mode_reg <= MODE_RDL_OFF;
          end else if (rxLoopAck) begin
            mode_reg <= MODE_RDL_LOCAL; // RQ13
          end
        end
        MODE_RDL_LOCAL: begin
          if (restartNow) begin
            mode_reg <= MODE_NORMAL; // RQ15
          end else if (sendOff) begin
            mode_reg <= MODE_RDL_OFF; // RQ17
          end
        end
        MODE_RDL_OFF: begin
          if (txDone && eocTxCode == `LTRC_EOC_LOOP_OFF) begin
            mode_reg <= MODE_NORMAL; // RQ17
          end
        end
        MODE_RDL_END: begin
          if (rxLoopOff || restartNow) begin
            mode_reg <= MODE_NORMAL;
          end
        end
        default: begin
          mode_reg <= MODE_NORMAL;
        end
      endcase
    end
  end

  // Out-of-band transmit: a message stands until the framer takes it
  always_ff @(posedge clock) begin
    if (srst) begin
      eocTxValid <= 1'b0;
      eocTxCode <= 2'h0;
    end else if (sendAck) begin
      eocTxValid <= 1'b1;
      eocTxCode <= `LTRC_EOC_LOOP_ACK; // RQ13
    end else if (sendOn) begin
      eocTxValid <= 1'b1;
      eocTxCode <= `LTRC_EOC_LOOP_ON; // RQ13
    end else if (sendOff) begin
      eocTxValid <= 1'b1;
      eocTxCode <= `LTRC_EOC_LOOP_OFF; // RQ17
    end else if (txDone) begin
      eocTxValid <= 1'b0;
    end
  end

  // Remote switch rearmed only after it returns to normal
  always_ff @(posedge clock) begin
    if (srst) begin
      swIgnore_reg <= 1'b0;
    end else if (mode_reg == MODE_RDL_OFF && pin_reg[1]) begin
      swIgnore_reg <= 1'b1; // RQ18
    end else if (!pin_reg[1]) begin
      swIgnore_reg <= 1'b0; // RQ18
    end
  end

  // Pattern generator with its own 45 second limit
  always_ff @(posedge clock) begin
    if (srst) begin
      patActive_reg <= 1'b0;
      patTimeout_reg <= 1'b0;
      patSecs_reg <= 6'h00;
    end else if (!patReq) begin
      patActive_reg <= 1'b0;
      patTimeout_reg <= 1'b0; // RQ3
      patSecs_reg <= 6'h00;
    end else if (mode_reg == MODE_LOCAL2 || mode_reg == MODE_RDL_END) begin
      patActive_reg <= 1'b0; // RQ12
      patSecs_reg <= 6'h00;
    end else if (!patActive_reg && !patTimeout_reg) begin
      patActive_reg <= 1'b1; // RQ10
      patSecs_reg <= 6'h00; // RQ23
    end else if (patActive_reg && tick_reg) begin
      if (patSecs_reg >= `LTRC_PATTERN_S - 6'h01) begin
        patActive_reg <= 1'b0; // RQ2
        patTimeout_reg <= 1'b1; // RQ3
      end else begin
        patSecs_reg <= patSecs_reg + 6'h01;
      end
    end
  end

  // Blink phase for the timed-out pattern indication
  always_ff @(posedge clock) begin
    if (srst || !patTimeout_reg) begin
      blinkCnt_reg <= 32'h0000_0000;
      blink_reg <= 1'b0;
    end else if (blinkCnt_reg >= 32'(BLINK_CYCLES - 1)) begin
      blinkCnt_reg <= 32'h0000_0000;
      blink_reg <= ~blink_reg; // RQ3
    end else begin
      blinkCnt_reg <= blinkCnt_reg + 32'h0000_0001;
    end
  end

  // Error flash: stretched so a single error is visible
  always_ff @(posedge clock) begin
    if (srst) begin
      flashCnt_reg <= 32'h0000_0000;
    end else if ((crcError && !patActive_reg) ||
                 (patBitError && patActive_reg)) begin
      flashCnt_reg <= 32'(FLASH_CYCLES); // RQ21
    end else if (flashCnt_reg != 32'h0000_0000) begin
      flashCnt_reg <= flashCnt_reg - 32'h0000_0001;
    end
  end

  // Indicators and status pins
  always_ff @(posedge clock) begin
    if (srst) begin
      errorIndicator <= 1'b0;
      noLinkIndicator <= 1'b1;
      testModeIndicator <= 1'b0;
      clearToSend <= 1'b0;
      carrierDetect <= 1'b0;
    end else begin
      errorIndicator <= patTimeout_reg ? blink_reg
                        : (flashCnt_reg != 32'h0000_0000); // RQ3 RQ21
      noLinkIndicator <= !linked;
      testModeIndicator <= (mode_reg != MODE_NORMAL) || patActive_reg; // RQ17
      if (framedPacket) begin
        clearToSend <= 1'b1; // RQ20
        carrierDetect <= 1'b1;
      end else if (unframedPacket || restartNow) begin
        clearToSend <= 1'b0; // RQ20
        carrierDetect <= 1'b0;
      end
    end
  end

  // Data path steering toward framer and loop control
  always_ff @(posedge clock) begin
    if (srst) begin
      patGenEnable <= 1'b0;
      patErrInject <= 1'b0;
      loopTermAtCtl <= 1'b0;
      loopTermAtFramer <= 1'b0;
      loopLineAtCtl <= 1'b0;
      patToDetector <= 1'b0;
      termRxValid <= 1'b1;
      termTxIgnore <= 1'b0;
    end else begin
      patGenEnable <= patActive_reg; // RQ12 RQ19
      patErrInject <= patActive_reg && pin_reg[5];
      loopTermAtCtl <= mode_reg == MODE_LOCAL1 && !patActive_reg; // RQ5
      loopTermAtFramer <= mode_reg == MODE_LOCAL2; // RQ7
      loopLineAtCtl <= mode_reg == MODE_LOCAL2 ||
                       mode_reg == MODE_RDL_END; // RQ7 RQ14
      patToDetector <= mode_reg == MODE_LOCAL1 && patActive_reg; // RQ9
      termRxValid <= !(mode_reg == MODE_LOCAL1 && patActive_reg); // RQ11
      termTxIgnore <= mode_reg == MODE_RDL_END; // RQ16
    end
  end

  // Wishbone slave: one wait state, ack for one cycle
  assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  always_ff @(posedge clock) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_reg <= 4'h0;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= 32'h0000_0000;
      if (wbReq && !wb_we_i) begin
        if (wb_adr_i == `LTRC_ADR_CTRL) begin
          wb_dat_o <= {28'h000_0000, ctrl_reg};
        end else if (wb_adr_i == `LTRC_ADR_STATUS) begin
          wb_dat_o <= {24'h00_0000, patTimeout_reg, patActive_reg,
                       swIgnore_reg, link_reg, 1'b0, mode_reg};
        end
      end
      if (wbReq && wb_we_i && wb_sel_i[0] &&
          wb_adr_i == `LTRC_ADR_CTRL) begin
        ctrl_reg <= wb_dat_i[3:0];
      end
    end
  end

endmodule
`default_nettype wire

// *** verification/ltrc_loop_test_ctrl_checker.sv ***
// Port assertions for the loop test and restart control block
`timescale 1ns/1ps
`default_nettype none
module ltrc_checker #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic framedPacket,
  input wire logic crcError,
  input wire logic eocTxReady,
  input wire logic eocTxValid,
  input wire logic [1:0] eocTxCode,
  input wire logic restartPulse,
  input wire logic clearToSend,
  input wire logic carrierDetect,
  input wire logic noLinkIndicator,
  input wire logic errorIndicator,
  input wire logic testModeIndicator,
  input wire logic patGenEnable,
  input wire logic loopTermAtFramer,
  input wire logic loopLineAtCtl,
  input wire logic termTxIgnore
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Cycles the generator has run without a break
  int unsigned genRun_reg;
  always_ff @(posedge clock) begin
    if (srst || !patGenEnable)
      genRun_reg <= 0;
    else
      genRun_reg <= genRun_reg + 1;
  end
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_cts_cd: assert property (clearToSend == carrierDetect)
    else $error("clear to send and carrier disagree");
  a_restart_unlinks: assert property (restartPulse |-> ##[1:2] noLinkIndicator)
    else $error("restart left link indicator off");
  a_framed_quiet: assert property (framedPacket |=> (!restartPulse)[*8])
    else $error("restart right after framed packet");
  a_eoc_stands: assert property (eocTxValid && !eocTxReady |=> eocTxValid)
    else $error("out of band message dropped");
  a_eoc_taken: assert property (eocTxValid && eocTxReady |=> !eocTxValid)
    else $error("out of band message kept after accept");
  a_tm_hold: assert property (eocTxValid && eocTxCode == 2'h3 |-> testModeIndicator)
    else $error("test indicator off during loop off");
  a_far_end_paths: assert property (termTxIgnore |-> loopLineAtCtl)
    else $error("far end ignores terminal without loop");
  a_mode2_no_gen: assert property (loopTermAtFramer |-> !patGenEnable)
    else $error("generator on in framer loop");
  a_crc_flash: assert property (crcError |=> ##[0:3] errorIndicator)
    else $error("crc error not flashed");
  a_gen_limit: assert property (genRun_reg <= 46 * TICK_CYCLES)
    else $error("pattern generator ran too long");
endmodule
bind ltrc_loop_test_ctrl ltrc_checker #(.TICK_CYCLES(TICK_CYCLES)) ltrc_checker_inst (
  .clock, .srst, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .framedPacket,
  .crcError, .eocTxReady, .eocTxValid, .eocTxCode, .restartPulse,
  .clearToSend, .carrierDetect, .noLinkIndicator, .errorIndicator,
  .testModeIndicator, .patGenEnable, .loopTermAtFramer, .loopLineAtCtl,
  .termTxIgnore
);
`default_nettype wire

// *** verification/ltrc_remote_unit.sv ***
// Behavioural far unit: framer packets and out-of-band replies
`timescale 1ns/1ps
`default_nettype none
module ltrc_remote_unit (
  input wire logic clock,
  input wire logic srst,
  input wire logic lineUp,
  input wire logic askOn,
  input wire logic askOff,
  input wire logic [4:0] readyDelay,
  input wire logic eocTxValid,
  input wire logic [1:0] eocTxCode,
  output logic framedPacket,
  output logic unframedPacket,
  output logic eocRxValid,
  output logic [1:0] eocRxCode,
  output logic eocTxReady
);
  logic [1:0] slot_reg;
  logic [4:0] wait_reg;
  logic ackDue_reg;
  // Dead line or idle far unit yields only unframed packets
  always_ff @(posedge clock) begin
    slot_reg <= srst ? 2'h0 : slot_reg + 2'h1;
    framedPacket <= !srst && slot_reg == 2'h0 && lineUp;
    unframedPacket <= !srst && slot_reg == 2'h0 && !lineUp;
  end
  always_ff @(posedge clock) begin
    if (srst || !eocTxValid || eocTxReady) begin
      wait_reg <= 5'h0;
      eocTxReady <= 1'b0;
    end else begin
      wait_reg <= wait_reg + 5'h1;
      eocTxReady <= wait_reg >= readyDelay;
    end
  end
  // Idle code toggles so a stale value is never trusted
  always_ff @(posedge clock) begin
    ackDue_reg <= !srst && eocTxValid && eocTxReady && eocTxCode == 2'h1;
    eocRxValid <= !srst && (ackDue_reg || askOn || askOff);
    eocRxCode <= srst ? 2'h0 : ackDue_reg ? 2'h2 : askOn ? 2'h1 :
                 askOff ? 2'h3 : ~eocRxCode;
  end
endmodule
`default_nettype wire

// *** verification/test_loopback_test_restart_control.sv ***
// Self-checking bench for the loop test and restart control block
`timescale 1ns/1ps
`default_nettype none
module test_loopback_test_restart_control import ltrc_pkg::*;;
  localparam int T = 20;
  logic clock, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic swLocalLoop, swRemoteLoop, termLocalLoop, termRemoteLoop;
  logic [1:0] prbsPatternSelect, eocRxCode, eocTxCode;
  logic framedPacket, unframedPacket, crcError, patBitError, eocRxValid;
  logic eocTxReady, eocTxValid, restartPulse, clearToSend, carrierDetect;
  logic noLinkIndicator, errorIndicator, testModeIndicator, patGenEnable;
  logic patErrInject, loopTermAtCtl, loopTermAtFramer, loopLineAtCtl;
  logic patToDetector, termRxValid, termTxIgnore, lineUp, askOn, askOff;
  logic prevErr;
  logic [4:0] readyDelay;
  int errors, checks, restarts, flips, r;
  ltrc_loop_test_ctrl #(.TICK_CYCLES(T), .BLINK_CYCLES(4), .FLASH_CYCLES(3))
    ltrc_loop_test_ctrl_inst (.clock, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .swLocalLoop,
    .swRemoteLoop, .prbsPatternSelect, .termLocalLoop, .termRemoteLoop,
    .framedPacket, .unframedPacket, .crcError, .patBitError, .eocRxValid,
    .eocRxCode, .eocTxReady, .eocTxValid, .eocTxCode, .restartPulse,
    .clearToSend, .carrierDetect, .noLinkIndicator, .errorIndicator,
    .testModeIndicator, .patGenEnable, .patErrInject, .loopTermAtCtl,
    .loopTermAtFramer, .loopLineAtCtl, .patToDetector, .termRxValid,
    .termTxIgnore);
  ltrc_remote_unit ltrc_remote_unit_inst (.clock, .srst, .lineUp, .askOn,
    .askOff, .readyDelay, .eocTxValid, .eocTxCode, .framedPacket,
    .unframedPacket, .eocRxValid, .eocRxCode, .eocTxReady);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (restartPulse === 1'b1) restarts++;
    if (errorIndicator !== prevErr) flips++;
    prevErr <= errorIndicator;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    chk("wbAck", 1, wb_ack_o);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    report_and_stop;
  end
  initial begin
    {srst, readyDelay} = {1'b1, 5'h2};
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {swLocalLoop, swRemoteLoop, termLocalLoop, termRemoteLoop} = 4'h0;
    {prbsPatternSelect, crcError, patBitError} = 4'h0;
    {lineUp, askOn, askOff} = 3'h0;
    wb_sel_i = 4'hf;
    cy(12);
    srst <= 1'b0;
    cy(1);
    chk("noLink", 1, noLinkIndicator);
    chk("termRx", 1, termRxValid);
    wb(1, 4'h8, 32'hffff_ffff);
    wb(0, 4'h8, 32'h0);
    chk("unmapped", 0, rd);
    swLocalLoop <= 1'b1;
    cy(8);
    wb(0, 4'h4, 32'h0);
    chk("mode1", MODE_LOCAL1, rd[2:0]);
    chk("loopCtl", 1, loopTermAtCtl);
    wb(1, 4'h0, 32'h4);
    cy(8);
    chk("patDet", 1, patToDetector);
    chk("termRxPat", 0, termRxValid);
    wb(1, 4'h0, 32'h0);
    swLocalLoop <= 1'b0;
    cy(8);
    r = restarts;
    cy(48 * T);
    chk("early", r, restarts);
    cy(5 * T);
    chk("startup", r + 1, restarts);
    $display("Test local loop 1 and startup done");
    lineUp <= 1'b1;
    cy(20);
    chk("cts", 1, clearToSend);
    chk("linked", 0, noLinkIndicator);
    lineUp <= 1'b0;
    r = restarts;
    cy(2 * T);
    chk("dataEarly", r, restarts);
    cy(4 * T);
    chk("dataRestart", r + 1, restarts);
    lineUp <= 1'b1;
    cy(20);
    $display("Test data restart done");
    prbsPatternSelect <= 2'h2;
    cy(8);
    chk("genOn", 1, patGenEnable);
    chk("inject", 1, patErrInject);
    lineUp <= 1'b0;
    r = restarts;
    cy(10 * T);
    chk("patHold", r, restarts);
    lineUp <= 1'b1;
    cy(32 * T);
    chk("genStill", 1, patGenEnable);
    cy(5 * T);
    chk("genOff", 0, patGenEnable);
    flips = 0;
    cy(40);
    chk("blink", 1, flips > 0);
    prbsPatternSelect <= 2'h0;
    cy(10);
    flips = 0;
    cy(40);
    chk("blinkOff", 0, flips);
    crcError <= 1'b1;
    cy(1);
    crcError <= 1'b0;
    cy(10);
    chk("crcFlash", 2, flips);
    $display("Test pattern timeout done");
    termLocalLoop <= 1'b1;
    cy(8);
    wb(0, 4'h4, 32'h0);
    chk("mode2", MODE_LOCAL2, rd[2:0]);
    chk("framerLoop", 1, loopTermAtFramer);
    chk("lineLoop", 1, loopLineAtCtl);
    wb(1, 4'h0, 32'h4);
    cy(8);
    chk("genMode2", 0, patGenEnable);
    wb(1, 4'h0, 32'h0);
    termLocalLoop <= 1'b0;
    cy(8);
    wb(0, 4'h4, 32'h0);
    chk("mode2Off", 8'h10, rd[7:0]);
    $display("Test local loop 2 done");
    readyDelay <= 5'h8;
    wb(1, 4'h0, 32'h2);
    cy(30);
    wb(0, 4'h4, 32'h0);
    chk("loopOn", 3'h4, rd[2:0]);
    wb(1, 4'h0, 32'h6);
    patBitError <= 1'b1;
    cy(1);
    patBitError <= 1'b0;
    cy(2);
    chk("bitErrFlash", 1, errorIndicator);
    lineUp <= 1'b0;
    r = restarts;
    cy(10 * T);
    chk("rdlPat", 1, patGenEnable);
    chk("rdlHold", r, restarts);
    lineUp <= 1'b1;
    wb(1, 4'h0, 32'h0);
    swRemoteLoop <= 1'b1;
    cy(2);
    chk("offCode", 3, eocTxCode);
    chk("tmHeld", 1, testModeIndicator);
    cy(30);
    wb(0, 4'h4, 32'h0);
    chk("ignored", 6'h30, rd[5:0]);
    swRemoteLoop <= 1'b0;
    cy(8);
    wb(0, 4'h4, 32'h0);
    chk("released", 6'h10, rd[5:0]);
    chk("tmOff", 0, testModeIndicator);
    $display("Test remote loop done");
    askOn <= 1'b1;
    cy(1);
    askOn <= 1'b0;
    cy(10);
    wb(0, 4'h4, 32'h0);
    chk("farEnd", 3'h6, rd[2:0]);
    chk("txIgnore", 1, termTxIgnore);
    lineUp <= 1'b0;
    r = restarts;
    cy(10 * T);
    chk("farHold", r, restarts);
    lineUp <= 1'b1;
    cy(20);
    askOff <= 1'b1;
    cy(1);
    askOff <= 1'b0;
    cy(10);
    wb(0, 4'h4, 32'h0);
    chk("farOff", MODE_NORMAL, rd[2:0]);
    $display("Test remote end done");
    report_and_stop;
  end
endmodule
`default_nettype wire
